//--- bridge_cfg_pkg.sv
// Constants, types and decode helpers for the bridge setpoint and configuration block
`default_nettype none
package bridge_cfg_pkg;

  // Clock and switching-timing limits
  localparam int CLK_MHZ = 100;
  localparam int MIN_ON_NS = 50;
  localparam int MIN_OFF_NS = 50;
  // Least times round up to whole clock cycles
  localparam int MIN_ON_CYC = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;

  // Setpoint code window and clamp steps
  localparam int SIGN_BIT = 25;
  localparam int CODE_W = 25;
  localparam logic signed [31:0] CODE_MIN = 32'shFF000000;
  localparam logic signed [31:0] CODE_MAX = 32'sh00FFFFFF;
  localparam logic signed [31:0] CLAMP_HI_BASE = 32'sh000FFFFF;
  localparam int CLAMP_SHIFT = 20;

  // Power cap decode
  localparam logic [3:0] PWR_CODE_2W = 4'h0;
  localparam logic [3:0] PWR_CODE_NOLIM = 4'h5;
  localparam logic [3:0] PWR_CODE_3W = 4'hA;
  localparam logic [3:0] PWR_CODE_3W5 = 4'hF;
  localparam logic [11:0] PWR_MW_2W = 12'h7D0;
  localparam logic [11:0] PWR_MW_3W = 12'hBB8;
  localparam logic [11:0] PWR_MW_3W5 = 12'hDAC;

  // Initial peak current levels in mA, ascending with the selector
  localparam logic [11:0] PEAK_MA [8] = '{12'h0FB, 12'h252, 12'h3A8, 12'h4FE,
                                         12'h654, 12'h7AA, 12'h900, 12'hA56};

  // Duty range limits in percent, indexed by the duty range selector
  localparam logic [6:0] DUTY_MIN_PCT [4] = '{7'h14, 7'h0F, 7'h0A, 7'h0A};
  localparam logic [6:0] DUTY_MAX_PCT [4] = '{7'h50, 7'h55, 7'h5A, 7'h5A};

  typedef enum logic [2:0] {
    SEL_SETPOINT, SEL_PEAK, SEL_PWR_HI, SEL_PWR_LO, SEL_DUTY, SEL_CLAMP_HI, SEL_CLAMP_LO
  } field_sel_e;

  typedef struct packed {
    logic signed [31:0] setpoint;
    logic [2:0] peak;
    logic [3:0] pwr_hi;
    logic [3:0] pwr_lo;
    logic [1:0] duty;
    logic [3:0] clamp_hi;
    logic [3:0] clamp_lo;
  } cfg_s;

  localparam cfg_s CFG_RST = '{setpoint: 32'sh00000000, peak: 3'h0, pwr_hi: 4'h5,
                               pwr_lo: 4'h5, duty: 2'h0, clamp_hi: 4'hF, clamp_lo: 4'h0};

  typedef struct packed {
    logic nolim;
    logic [11:0] mw;
  } pwr_s;

  typedef struct packed {
    logic [6:0] min_pct;
    logic [6:0] max_pct;
  } duty_s;

  function automatic logic signed [31:0] clamp_s(input logic signed [31:0] v,
                                                 input logic signed [31:0] lo,
                                                 input logic signed [31:0] hi);
    clamp_s = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Undocumented codes round down to the nearest documented band
  function automatic pwr_s pwr_decode(input logic [3:0] c);
    pwr_decode.nolim = (c >= PWR_CODE_NOLIM) && (c < PWR_CODE_3W);
    if (c == PWR_CODE_3W5)
      pwr_decode.mw = PWR_MW_3W5;
    else if (c >= PWR_CODE_3W)
      pwr_decode.mw = PWR_MW_3W;
    else if (c < PWR_CODE_NOLIM)
      pwr_decode.mw = PWR_MW_2W;
    else
      pwr_decode.mw = 12'h000;
  endfunction

endpackage
`default_nettype wire

//--- bridge_setpoint_config_decode.sv
// Setpoint and configuration decode for the full-bridge driver
`timescale 1ns/10ps
`default_nettype none

// How it works
// (RULE1) Three-bit peak selector decodes to eight ascending levels, 0.251A up to 2.646A.
// (RULE2) Selected peak current is applied when the switching driver becomes enabled.
// (RULE3) Host picks the peak code nearest its computed optimum.
// (RULE4) Two independent four-bit power caps: 2W, no limit, 3W, 3.5W.
// (RULE5) Setpoint bits 31 to 26 always copy bit 25.
// (RULE6) Setpoint is held within 0xFF000000 through 0x00FFFFFF.
// (RULE7) Zero code gives zero output; otherwise output is linear in the code.
// (RULE8) Host regulates by measuring and rewriting the setpoint.
// (RULE9) Duty selector: 00 is 20-80%, 01 is 15-85%, 10/11 is 10-90%.
// (RULE10) Duty selector never changes the code delivered to the converter.
// (RULE11) On-time under 50ns flags pulse skipping.
// (RULE12) Off-time under 50ns flags pulse skipping.
// (RULE13) Host keeps duty range and setpoint away from extreme operating points.
// (RULE14) Upper and lower four-bit clamps bound the code in sixteenth steps.
// (RULE15) Fields hold their values until rewritten or reset.
module bridge_setpoint_config_decode
  import bridge_cfg_pkg::*;
#(
  parameter int TW = 16
) (
  input wire logic core_clk, // Core clock, 100 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic wr_en, // Field write strobe from the serial port
  input wire field_sel_e wr_sel, // Field addressed by the write
  input wire logic [31:0] wr_data, // Write data, field in the low bits
  input wire field_sel_e rd_sel, // Field selected for readback
  output logic [31:0] rd_data, // Readback of rd_sel, one cycle later
  input wire logic pwm_en, // Switching driver enable level
  input wire logic [TW-1:0] pwm_period, // Switching period in core cycles
  input wire logic [TW-1:0] pwm_ontime, // Requested on-time in core cycles
  output logic [11:0] peak_ma, // Applied initial peak current, mA
  output pwr_s pwr_hi, // High-side linear power cap
  output pwr_s pwr_lo, // Low-side linear power cap
  output duty_s duty_lim, // PWM duty-cycle limits
  output logic signed [CODE_W-1:0] dac_code, // Clamped code to the converter
  output logic skip_on, // Pulse skipping for short on-time
  output logic skip_off // Pulse skipping for short off-time
);

  localparam logic [TW-1:0] ON_CYC = TW'(MIN_ON_CYC);
  localparam logic [TW-1:0] OFF_CYC = TW'(MIN_OFF_CYC);

  typedef struct packed {
    cfg_s cfg;
    logic pwm_en;
    logic [11:0] peak_ma;
    pwr_s pwr_hi;
    pwr_s pwr_lo;
    duty_s duty;
    logic signed [CODE_W-1:0] code;
    logic [31:0] rd_data;
    logic skip_on;
    logic skip_off;
  } state_s;

  state_s state_q;
  state_s state_d;

  function automatic logic signed [31:0] clamp_lo_lim(input logic [3:0] c);
    clamp_lo_lim = CODE_MIN + $signed({8'h00, c, 20'h00000});
  endfunction

  function automatic logic signed [31:0] clamp_hi_lim(input logic [3:0] c);
    clamp_hi_lim = CLAMP_HI_BASE + $signed({8'h00, c, 20'h00000});
  endfunction

  always_comb
  begin
    logic signed [31:0] sx;
    logic signed [31:0] eff;
    sx = '0;
    eff = '0;
    state_d = state_q;
    state_d.pwm_en = pwm_en;
    if (wr_en)
    begin
      unique case (wr_sel)
        SEL_SETPOINT:
        begin
          // Sign-extend from bit 25, then hold inside the converter's signed span
          sx = {{6{wr_data[SIGN_BIT]}}, wr_data[SIGN_BIT:0]}; // RULE5
          state_d.cfg.setpoint = clamp_s(sx, CODE_MIN, CODE_MAX); // RULE6
        end
        SEL_PEAK: state_d.cfg.peak = wr_data[2:0];
        SEL_PWR_HI: state_d.cfg.pwr_hi = wr_data[3:0];
        SEL_PWR_LO: state_d.cfg.pwr_lo = wr_data[3:0];
        SEL_DUTY: state_d.cfg.duty = wr_data[1:0];
        SEL_CLAMP_HI: state_d.cfg.clamp_hi = wr_data[3:0];
        SEL_CLAMP_LO: state_d.cfg.clamp_lo = wr_data[3:0];
        default: state_d.cfg = state_q.cfg; // RULE15
      endcase
    end
    // Peak level is captured only on the enable edge, so later selector writes
    // do not disturb a running converter
    if (pwm_en && !state_q.pwm_en)
      state_d.peak_ma = PEAK_MA[state_q.cfg.peak]; // RULE1 RULE2
    state_d.pwr_hi = pwr_decode(state_q.cfg.pwr_hi); // RULE4
    state_d.pwr_lo = pwr_decode(state_q.cfg.pwr_lo); // RULE4
    state_d.duty.min_pct = DUTY_MIN_PCT[state_q.cfg.duty]; // RULE9
    state_d.duty.max_pct = DUTY_MAX_PCT[state_q.cfg.duty]; // RULE9
    // Code path ignores the duty selector entirely
    eff = clamp_s(state_q.cfg.setpoint, clamp_lo_lim(state_q.cfg.clamp_lo),
                  clamp_hi_lim(state_q.cfg.clamp_hi)); // RULE14 RULE10
    state_d.code = eff[CODE_W-1:0]; // RULE7
    state_d.skip_on = pwm_ontime < ON_CYC; // RULE11
    state_d.skip_off = (pwm_ontime >= pwm_period) || ((pwm_period - pwm_ontime) < OFF_CYC); // RULE12
    unique case (rd_sel)
      SEL_SETPOINT: state_d.rd_data = state_q.cfg.setpoint;
      SEL_PEAK: state_d.rd_data = {29'h0, state_q.cfg.peak};
      SEL_PWR_HI: state_d.rd_data = {28'h0, state_q.cfg.pwr_hi};
      SEL_PWR_LO: state_d.rd_data = {28'h0, state_q.cfg.pwr_lo};
      SEL_DUTY: state_d.rd_data = {30'h0, state_q.cfg.duty};
      SEL_CLAMP_HI: state_d.rd_data = {28'h0, state_q.cfg.clamp_hi};
      SEL_CLAMP_LO: state_d.rd_data = {28'h0, state_q.cfg.clamp_lo};
      default: state_d.rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_q <= '0;
      state_q.cfg <= CFG_RST; // RULE15
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign rd_data = state_q.rd_data;
  assign peak_ma = state_q.peak_ma;
  assign pwr_hi = state_q.pwr_hi;
  assign pwr_lo = state_q.pwr_lo;
  assign duty_lim = state_q.duty;
  assign dac_code = state_q.code;
  assign skip_on = state_q.skip_on;
  assign skip_off = state_q.skip_off;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  peak_apply_a: assert property ( // RULE2
    $rose(pwm_en) |=> ##1 peak_ma == PEAK_MA[$past(state_q.cfg.peak, 2)])
    else $error("peak current not applied on enable");

  peak_steady_a: assert property ( // RULE2
    $stable(pwm_en) && $past(rstn) |=> $stable(peak_ma))
    else $error("peak current moved without an enable edge");

  pwr_nolim_a: assert property ( // RULE4
    state_q.cfg.pwr_lo == PWR_CODE_NOLIM |=> pwr_lo.nolim && pwr_lo.mw == 12'h000)
    else $error("low-side cap no-limit code not decoded");

  pwr_3w5_a: assert property ( // RULE4
    state_q.cfg.pwr_hi == PWR_CODE_3W5 |=> pwr_hi.mw == PWR_MW_3W5 && !pwr_hi.nolim)
    else $error("high-side cap 3.5W code not decoded");

  sign_ext_a: assert property ( // RULE5
    state_q.cfg.setpoint[31:26] == {6{state_q.cfg.setpoint[SIGN_BIT]}})
    else $error("setpoint not sign-extended");

  code_span_a: assert property ( // RULE6
    wr_en && wr_sel == SEL_SETPOINT |=> state_q.cfg.setpoint >= CODE_MIN && state_q.cfg.setpoint <= CODE_MAX)
    else $error("setpoint left the converter span");

  zero_code_a: assert property ( // RULE7
    state_q.cfg.setpoint == 32'sh0 |=> dac_code == '0)
    else $error("zero setpoint did not give zero code");

  duty_map_a: assert property ( // RULE9
    wr_en && wr_sel == SEL_DUTY && wr_data[1] |=> ##1 duty_lim.min_pct == 7'h0A && duty_lim.max_pct == 7'h5A)
    else $error("duty range 10-90 not selected");

  duty_indep_a: assert property ( // RULE10
    $changed(state_q.cfg.duty) && $stable(state_q.cfg.setpoint) && $stable(state_q.cfg.clamp_hi)
      && $stable(state_q.cfg.clamp_lo) |=> $stable(dac_code))
    else $error("duty selector disturbed the code");

  skip_on_a: assert property ( // RULE11
    pwm_ontime < ON_CYC |=> skip_on)
    else $error("short on-time not flagged");

  skip_off_a: assert property ( // RULE12
    pwm_ontime < pwm_period && (pwm_period - pwm_ontime) >= OFF_CYC |=> !skip_off)
    else $error("off-time flagged though long enough");

  clamp_bound_a: assert property ( // RULE14
    1'b1 |=> $signed(dac_code) <= clamp_hi_lim($past(state_q.cfg.clamp_hi))
      && $signed(dac_code) >= clamp_lo_lim($past(state_q.cfg.clamp_lo)))
    else $error("code escaped the clamp window");

  field_hold_a: assert property ( // RULE15
    !wr_en |=> $stable(state_q.cfg))
    else $error("field changed without a write");

  enable_cv: cover property ($rose(pwm_en) ##2 peak_ma == PEAK_MA[7]);
  clamp_cv: cover property (state_q.cfg.setpoint == CODE_MAX && state_q.cfg.clamp_hi == 4'h0);
  skip_cv: cover property (skip_on ##1 skip_off);
  duty_cv: cover property ($changed(duty_lim) && $stable(dac_code));

endmodule // bridge_setpoint_config_decode
`default_nettype wire

//--- bridge_setpoint_config_decode_bench.sv
// Self-checking bench for the setpoint and configuration decode block
`timescale 1ns/10ps
`default_nettype none
module bridge_setpoint_config_decode_bench
  import bridge_cfg_pkg::*;
;
  localparam logic [11:0] PK [8] = '{12'h0FB, 12'h252, 12'h3A8, 12'h4FE, 12'h654, 12'h7AA, 12'h900, 12'hA56};
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_en;
  field_sel_e wr_sel;
  field_sel_e rd_sel = SEL_SETPOINT;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic pwm_en = 1'b0;
  logic [15:0] pwm_period = 16'h0014;
  logic [15:0] pwm_ontime = 16'h000A;
  logic [11:0] peak_ma;
  pwr_s pwr_hi;
  pwr_s pwr_lo;
  duty_s duty_lim;
  logic signed [CODE_W-1:0] dac_code;
  logic skip_on;
  logic skip_off;
  int miscompares = 0;
  int compares = 0;
  integer seed = 32'hA08F;
  logic [31:0] sp;
  logic [3:0] hc, lc, chi, clo;
  logic [1:0] dc;

  always #5 core_clk = ~core_clk;

  host_model host_model_inst (.core_clk(core_clk), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data));
  bridge_setpoint_config_decode #(.TW(16)) bridge_setpoint_config_decode_inst (
    .core_clk(core_clk), .rstn(rstn), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
    .rd_sel(rd_sel), .rd_data(rd_data), .pwm_en(pwm_en), .pwm_period(pwm_period),
    .pwm_ontime(pwm_ontime), .peak_ma(peak_ma), .pwr_hi(pwr_hi), .pwr_lo(pwr_lo),
    .duty_lim(duty_lim), .dac_code(dac_code), .skip_on(skip_on), .skip_off(skip_off));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Three edges cover every decode path after a write or input change
  task automatic settle();
    repeat (3) @(negedge core_clk);
  endtask

  function automatic logic signed [31:0] sat(input logic [31:0] d);
    logic signed [31:0] v;
    v = {{6{d[25]}}, d[25:0]};
    sat = (v < CODE_MIN) ? CODE_MIN : ((v > CODE_MAX) ? CODE_MAX : v);
  endfunction

  function automatic logic [24:0] exp_dac(input logic signed [31:0] s, input logic [3:0] h, input logic [3:0] l);
    logic signed [31:0] a, b;
    a = CODE_MIN + {8'h00, l, 20'h00000};
    b = 32'sh000FFFFF + {8'h00, h, 20'h00000};
    exp_dac = (s < a) ? a[24:0] : ((s > b) ? b[24:0] : s[24:0]);
  endfunction

  function automatic pwr_s exp_pwr(input logic [3:0] c);
    exp_pwr.nolim = (c > 4'h4) && (c < 4'hA);
    exp_pwr.mw = (c == 4'hF) ? PWR_MW_3W5 : (c > 4'h9) ? PWR_MW_3W : (c < 4'h5) ? PWR_MW_2W : 12'h000;
  endfunction

  function automatic duty_s exp_duty(input logic [1:0] d);
    exp_duty = (d == 2'h0) ? {7'h14, 7'h50} : (d == 2'h1) ? {7'h0F, 7'h55} : {7'h0A, 7'h5A};
  endfunction

  initial
  begin
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    host_model_inst.wr(field_sel_e'(3'h7), 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++)
    begin
      rd_sel = field_sel_e'(i);
      settle();
      check("rd_data", rd_data, (i == 2 || i == 3) ? 32'h5 : (i == 5) ? 32'hF : 32'h0);
    end
    for (int i = 0; i < 8; i++)
    begin
      host_model_inst.wr(SEL_PEAK, i);
      pwm_en = 1'b1;
      settle();
      // A new selector while enabled must wait for the next enable edge
      host_model_inst.wr(SEL_PEAK, 7 - i);
      settle();
      check("peak_ma", peak_ma, PK[i]);
      pwm_en = 1'b0;
    end
    rd_sel = SEL_SETPOINT;
    for (int n = 0; n < 40; n++)
    begin
      hc = 4'($random(seed));
      lc = 4'($random(seed));
      chi = (n < 3) ? 4'hF : 4'($random(seed));
      clo = (n < 3) ? 4'h0 : 4'($random(seed));
      dc = 2'($random(seed));
      sp = (n == 0) ? 32'h02000000 : (n == 1) ? 32'h01FFFFFF : (n == 2) ? 32'h00000000 : 32'($random(seed));
      pwm_period = 16'h0005 + (16'($random(seed)) & 16'h003F);
      pwm_ontime = (n == 3) ? 16'h0004 : (16'($random(seed)) & 16'h003F);
      host_model_inst.wr(SEL_PWR_HI, hc);
      host_model_inst.wr(SEL_PWR_LO, lc);
      host_model_inst.wr(SEL_CLAMP_HI, chi);
      host_model_inst.wr(SEL_CLAMP_LO, clo);
      host_model_inst.wr(SEL_SETPOINT, sp);
      settle();
      check("rd_data", rd_data, sat(sp));
      check("dac_code", {7'h00, dac_code}, {7'h00, exp_dac(sat(sp), chi, clo)});
      check("pwr_hi", pwr_hi, exp_pwr(hc));
      check("pwr_lo", pwr_lo, exp_pwr(lc));
      check("skip_on", skip_on, pwm_ontime < 16'h0005);
      check("skip_off", skip_off, pwm_ontime >= pwm_period || pwm_period - pwm_ontime < 16'h0005);
      host_model_inst.wr(SEL_DUTY, dc);
      settle();
      check("duty_lim", duty_lim, exp_duty(dc));
      check("dac_code", {7'h00, dac_code}, {7'h00, exp_dac(sat(sp), chi, clo)});
    end
    results();
  end

  // Whole run is about a thousand cycles; ten thousand means a hang
  initial
  begin
    #100000;
    miscompares++;
    results();
  end
endmodule // bridge_setpoint_config_decode_bench
`default_nettype wire

//--- host_model.sv
// Host model that writes configuration fields over the register port
`timescale 1ns/10ps
`default_nettype none
module host_model
  import bridge_cfg_pkg::*;
(
  input wire logic core_clk, // Core clock
  output logic wr_en, // Write strobe
  output field_sel_e wr_sel, // Field written
  output logic [31:0] wr_data // Write data
);
  initial
  begin
    wr_en = 1'b0;
    wr_sel = SEL_SETPOINT;
    wr_data = 32'h00000000;
  end
  // Data is inverted after the strobe so nothing can lean on a stale bus
  task automatic wr(input field_sel_e sel, input logic [31:0] d);
    @(negedge core_clk);
    wr_en = 1'b1;
    wr_sel = sel;
    wr_data = d;
    @(negedge core_clk);
    wr_en = 1'b0;
    wr_data = ~d;
  endtask
endmodule // host_model
`default_nettype wire
